// ==== shared/semc_defs.svh ====
// Timing, width and encoding constants for the semaphore port controller.
`ifndef SEMC_DEFS_SVH
`define SEMC_DEFS_SVH

`define SEMC_CLK_PERIOD_NS 50
`define SEMC_STROBE_NS     55
`define SEMC_GAP_NS        50
`define SEMC_STROBE_CYC    (((`SEMC_STROBE_NS) + (`SEMC_CLK_PERIOD_NS) - 1) / (`SEMC_CLK_PERIOD_NS))
`define SEMC_GAP_CYC       (((`SEMC_GAP_NS) + (`SEMC_CLK_PERIOD_NS) - 1) / (`SEMC_CLK_PERIOD_NS))
`define SEMC_CNT_W         3
`define SEMC_DATA_W        16
`define SEMC_IDX_W         3
`define SEMC_IDX_FIRST     3'h0
`define SEMC_IDX_LAST      3'h7
`define SEMC_ACQ_READS     3'h4
`define SEMC_FLAG_FREE     1'b1
`define SEMC_FLAG_TAKEN    1'b0
`define SEMC_PIN_INACTIVE  1'b1
`define SEMC_PIN_ACTIVE    1'b0

`endif

// ==== shared/semc_pkg.sv ====
// Types shared by the semaphore port controller modules.
`include "semc_defs.svh"
package semc_pkg;

   typedef enum logic [1:0] {
      SEMC_OP_INIT    = 2'b00,
      SEMC_OP_ACQUIRE = 2'b01,
      SEMC_OP_RELEASE = 2'b10,
      SEMC_OP_PEEK    = 2'b11
   } semc_op_e;

   typedef struct packed {
      semc_op_e                 op;
      logic [`SEMC_IDX_W-1:0]   idx;
   } semc_cmd_s;

   typedef struct packed {
      semc_op_e op;
      logic     granted;
      logic     flag;
   } semc_rsp_s;

   typedef struct packed {
      logic                     flag_space_select_n;
      logic                     chip_enable_n;
      logic                     out_enable_n;
      logic                     read_write_n;
      logic [`SEMC_IDX_W-1:0]   flag_index_lines;
   } semc_pins_s;

   typedef enum logic [2:0] {
      SEMC_SQ_IDLE   = 3'b000,
      SEMC_SQ_SETUP  = 3'b001,
      SEMC_SQ_STROBE = 3'b010,
      SEMC_SQ_HOLD   = 3'b011,
      SEMC_SQ_GAP    = 3'b100
   } semc_sq_e;

   typedef enum logic [2:0] {
      SEMC_ST_INIT    = 3'b000,
      SEMC_ST_IDLE    = 3'b001,
      SEMC_ST_ACQ_WR  = 3'b010,
      SEMC_ST_ACQ_RD  = 3'b011,
      SEMC_ST_ACQ_REL = 3'b100,
      SEMC_ST_REL_WR  = 3'b101,
      SEMC_ST_PEEK_RD = 3'b110,
      SEMC_ST_RESP    = 3'b111
   } semc_st_e;

endpackage : semc_pkg

// ==== rtl/semc_bus_cycle.sv ====
// One semaphore-space bus cycle on the port pins, read or write.
`include "semc_defs.svh"
module semc_bus_cycle
   import semc_pkg::*;
(
   // Clock and reset.
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   // Cycle request.
   input  wire logic                    start,
   input  wire logic                    is_write,
   input  wire logic                    wbit,
   input  wire logic [`SEMC_IDX_W-1:0]  idx,
   // Cycle result.
   output logic                         done_r,
   output logic                         rdata_r,
   // Port pins.
   output semc_pins_s                   pins_r,
   input  wire logic [`SEMC_DATA_W-1:0] dq_in,
   output logic [`SEMC_DATA_W-1:0]      dq_out_r,
   output logic                         dq_oe_r
);

   semc_sq_e                  sq_r,     sq_nxt;
   logic [`SEMC_CNT_W-1:0]    cnt_r,    cnt_nxt;
   logic                      wr_r,     wr_nxt;
   logic                      done_nxt;
   logic                      rdata_nxt;
   semc_pins_s                pins_nxt;
   logic [`SEMC_DATA_W-1:0]   dq_out_nxt;
   logic                      dq_oe_nxt;

   always_comb begin
      sq_nxt     = sq_r;
      cnt_nxt    = cnt_r;
      wr_nxt     = wr_r;
      done_nxt   = 1'b0;
      rdata_nxt  = rdata_r;
      pins_nxt   = pins_r;
      dq_out_nxt = dq_out_r;
      dq_oe_nxt  = dq_oe_r;
      // Memory enable stays inactive so every access lands in flag space.
      // Memory enable high.
      pins_nxt.chip_enable_n = `SEMC_PIN_INACTIVE;
      unique case (sq_r)
         SEMC_SQ_IDLE: begin
            if (start) begin
               sq_nxt                       = SEMC_SQ_SETUP;
               wr_nxt                       = is_write;
               pins_nxt.flag_space_select_n = `SEMC_PIN_ACTIVE;
               pins_nxt.flag_index_lines    = idx;
               dq_out_nxt = {{(`SEMC_DATA_W-1){1'b0}}, wbit};
               dq_oe_nxt  = is_write;
            end
         end
         SEMC_SQ_SETUP: begin
            sq_nxt  = SEMC_SQ_STROBE;
            cnt_nxt = '0;
            if (wr_r) begin
               pins_nxt.read_write_n = `SEMC_PIN_ACTIVE;
            end else begin
               pins_nxt.out_enable_n = `SEMC_PIN_ACTIVE;
            end
         end
         SEMC_SQ_STROBE: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == `SEMC_CNT_W'(`SEMC_STROBE_CYC - 1)) begin
               sq_nxt                = SEMC_SQ_HOLD;
               pins_nxt.read_write_n = `SEMC_PIN_INACTIVE;
               pins_nxt.out_enable_n = `SEMC_PIN_INACTIVE;
               if (!wr_r) begin
                  rdata_nxt = dq_in[0];
               end
            end
         end
         SEMC_SQ_HOLD: begin
            sq_nxt                       = SEMC_SQ_GAP;
            cnt_nxt                      = '0;
            pins_nxt.flag_space_select_n = `SEMC_PIN_INACTIVE;
            dq_oe_nxt                    = 1'b0;
         end
         SEMC_SQ_GAP: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == `SEMC_CNT_W'(`SEMC_GAP_CYC - 1)) begin
               sq_nxt   = SEMC_SQ_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: begin
            sq_nxt = SEMC_SQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sq_r     <= SEMC_SQ_IDLE;
         cnt_r    <= '0;
         wr_r     <= 1'b0;
         done_r   <= 1'b0;
         rdata_r  <= `SEMC_FLAG_FREE;
         pins_r   <= '{flag_space_select_n: `SEMC_PIN_INACTIVE,
                       chip_enable_n:       `SEMC_PIN_INACTIVE,
                       out_enable_n:        `SEMC_PIN_INACTIVE,
                       read_write_n:        `SEMC_PIN_INACTIVE,
                       flag_index_lines:    `SEMC_IDX_FIRST};
         dq_out_r <= '0;
         dq_oe_r  <= 1'b0;
      end else begin
         sq_r     <= sq_nxt;
         cnt_r    <= cnt_nxt;
         wr_r     <= wr_nxt;
         done_r   <= done_nxt;
         rdata_r  <= rdata_nxt;
         pins_r   <= pins_nxt;
         dq_out_r <= dq_out_nxt;
         dq_oe_r  <= dq_oe_nxt;
      end
   end

   property p_strobe_in_space;
      @(posedge core_clk) disable iff (srst)
      (!pins_r.out_enable_n || !pins_r.read_write_n) |->
         (!pins_r.flag_space_select_n && pins_r.chip_enable_n);
   endproperty
   a_strobe_in_space: assert property (p_strobe_in_space)
      else $error("Strobe active outside flag space.");

   property p_read_gap;
      @(posedge core_clk) disable iff (srst)
      $rose(pins_r.out_enable_n) |=> pins_r.flag_space_select_n;
   endproperty
   a_read_gap: assert property (p_read_gap)
      else $error("Select not dropped after a read.");

   property p_strobe_width;
      @(posedge core_clk) disable iff (srst)
      $fell(pins_r.out_enable_n) |-> !pins_r.out_enable_n [*2] ##1 pins_r.out_enable_n;
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("Read strobe width wrong.");

   property p_ce_high;
      @(posedge core_clk) disable iff (srst)
      !pins_r.flag_space_select_n |-> pins_r.chip_enable_n;
   endproperty
   a_ce_high: assert property (p_ce_high)
      else $error("Memory enable active during flag access.");

endmodule : semc_bus_cycle

// ==== rtl/semc_ctrl.sv ====
// Port-side controller that takes, releases and reads the dual-port flags.
`include "semc_defs.svh"
// What this block does
// - Flags active low; write zero requests, same port writes one releases.
// - Flag space selected by select low; strobes used as static memory.
// - Drop select or output enable between repeated reads.
// - Acquire by writing zero then reading, never read then write.
// - Failed request followed by re-reads, then writing one.
// - Flag accesses keep memory enable high and select low.
// - Write one to every flag at start-up.
module semc_ctrl
   import semc_pkg::*;
(
   // Clock and reset.
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   // Command port.
   input  wire logic                    cmd_valid,
   input  semc_cmd_s                    cmd,
   output logic                         cmd_ready_r,
   // Response port.
   output logic                         rsp_valid_r,
   output semc_rsp_s                    rsp_r,
   // Device port pins.
   output semc_pins_s                   pins_r,
   input  wire logic [`SEMC_DATA_W-1:0] dq_in,
   output logic [`SEMC_DATA_W-1:0]      dq_out_r,
   output logic                         dq_oe_r
);

   semc_st_e                  state_r,   state_nxt;
   logic [`SEMC_IDX_W-1:0]    idx_r,     idx_nxt;
   semc_op_e                  op_r,      op_nxt;
   logic [`SEMC_CNT_W-1:0]    tries_r,   tries_nxt;
   logic                      issued_r,  issued_nxt;
   logic                      boot_r,    boot_nxt;
   logic                      granted_r, granted_nxt;
   logic                      flag_r,    flag_nxt;
   logic                      cmd_ready_nxt;
   logic                      rsp_valid_nxt;
   semc_rsp_s                 rsp_nxt;
   logic                      seq_start;
   logic                      seq_done;
   logic                      seq_rdata;
   logic [2:0]                acc;

   // Returns {is_access, is_write, write_bit} for a controller state.
   function automatic logic [2:0] access_kind(input semc_st_e st);
      unique case (st)
         SEMC_ST_INIT:    access_kind = {1'b1, 1'b1, `SEMC_FLAG_FREE};
         SEMC_ST_ACQ_WR:  access_kind = {1'b1, 1'b1, `SEMC_FLAG_TAKEN};
         SEMC_ST_ACQ_RD:  access_kind = {1'b1, 1'b0, `SEMC_FLAG_FREE};
         SEMC_ST_ACQ_REL: access_kind = {1'b1, 1'b1, `SEMC_FLAG_FREE};
         SEMC_ST_REL_WR:  access_kind = {1'b1, 1'b1, `SEMC_FLAG_FREE};
         SEMC_ST_PEEK_RD: access_kind = {1'b1, 1'b0, `SEMC_FLAG_FREE};
         SEMC_ST_IDLE:    access_kind = 3'h0;
         SEMC_ST_RESP:    access_kind = 3'h0;
      endcase
   endfunction : access_kind

   assign acc       = access_kind(state_r);
   assign seq_start = acc[2] && !issued_r;

   semc_bus_cycle u_cycle (
      .core_clk (core_clk),
      .srst     (srst),
      .start    (seq_start),
      .is_write (acc[1]),
      .wbit     (acc[0]),
      .idx      (idx_r),
      .done_r   (seq_done),
      .rdata_r  (seq_rdata),
      .pins_r   (pins_r),
      .dq_in    (dq_in),
      .dq_out_r (dq_out_r),
      .dq_oe_r  (dq_oe_r)
   );

   always_comb begin
      state_nxt     = state_r;
      idx_nxt       = idx_r;
      op_nxt        = op_r;
      tries_nxt     = tries_r;
      issued_nxt    = issued_r;
      boot_nxt      = boot_r;
      granted_nxt   = granted_r;
      flag_nxt      = flag_r;
      rsp_valid_nxt = 1'b0;
      rsp_nxt       = rsp_r;
      if (seq_start) begin
         issued_nxt = 1'b1;
      end
      if (seq_done) begin
         issued_nxt = 1'b0;
      end
      unique case (state_r)
         SEMC_ST_INIT: begin
            if (seq_done) begin
               if (idx_r == `SEMC_IDX_LAST) begin
                  boot_nxt  = 1'b0;
                  flag_nxt  = `SEMC_FLAG_FREE;
                  state_nxt = boot_r ? SEMC_ST_IDLE : SEMC_ST_RESP;
               end else begin
                  idx_nxt = idx_r + 1'b1;
               end
            end
         end
         SEMC_ST_IDLE: begin
            if (cmd_valid && cmd_ready_r) begin
               op_nxt      = cmd.op;
               idx_nxt     = cmd.idx;
               tries_nxt   = '0;
               granted_nxt = 1'b0;
               unique case (cmd.op)
                  SEMC_OP_INIT: begin
                     idx_nxt   = `SEMC_IDX_FIRST;
                     state_nxt = SEMC_ST_INIT;
                  end
                  SEMC_OP_ACQUIRE: state_nxt = SEMC_ST_ACQ_WR;
                  SEMC_OP_RELEASE: state_nxt = SEMC_ST_REL_WR;
                  SEMC_OP_PEEK:    state_nxt = SEMC_ST_PEEK_RD;
               endcase
            end
         end
         SEMC_ST_ACQ_WR: begin
            if (seq_done) begin
               state_nxt = SEMC_ST_ACQ_RD;
            end
         end
         SEMC_ST_ACQ_RD: begin
            if (seq_done) begin
               flag_nxt = seq_rdata;
               if (seq_rdata == `SEMC_FLAG_TAKEN) begin
                  granted_nxt = 1'b1;
                  state_nxt   = SEMC_ST_RESP;
               end else if (tries_r == `SEMC_ACQ_READS - 1'b1) begin
                  state_nxt = SEMC_ST_ACQ_REL;
               end else begin
                  tries_nxt = tries_r + 1'b1;
               end
            end
         end
         SEMC_ST_ACQ_REL: begin
            if (seq_done) begin
               state_nxt = SEMC_ST_RESP;
            end
         end
         SEMC_ST_REL_WR: begin
            if (seq_done) begin
               flag_nxt  = `SEMC_FLAG_FREE;
               state_nxt = SEMC_ST_RESP;
            end
         end
         SEMC_ST_PEEK_RD: begin
            if (seq_done) begin
               flag_nxt  = seq_rdata;
               state_nxt = SEMC_ST_RESP;
            end
         end
         SEMC_ST_RESP: begin
            rsp_valid_nxt = 1'b1;
            rsp_nxt       = '{op: op_r, granted: granted_r, flag: flag_r};
            state_nxt     = SEMC_ST_IDLE;
         end
      endcase
      cmd_ready_nxt = (state_nxt == SEMC_ST_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r     <= SEMC_ST_INIT;
         idx_r       <= `SEMC_IDX_FIRST;
         op_r        <= SEMC_OP_INIT;
         tries_r     <= '0;
         issued_r    <= 1'b0;
         boot_r      <= 1'b1;
         granted_r   <= 1'b0;
         flag_r      <= `SEMC_FLAG_FREE;
         cmd_ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_r       <= '0;
      end else begin
         state_r     <= state_nxt;
         idx_r       <= idx_nxt;
         op_r        <= op_nxt;
         tries_r     <= tries_nxt;
         issued_r    <= issued_nxt;
         boot_r      <= boot_nxt;
         granted_r   <= granted_nxt;
         flag_r      <= flag_nxt;
         cmd_ready_r <= cmd_ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_r       <= rsp_nxt;
      end
   end

   property p_read_after_write;
      @(posedge core_clk) disable iff (srst)
      (state_r == SEMC_ST_ACQ_RD) && !$stable(state_r) |-> $past(state_r) == SEMC_ST_ACQ_WR;
   endproperty
   a_read_after_write: assert property (p_read_after_write)
      else $error("Acquire read not preceded by its write.");

   property p_request_zero;
      @(posedge core_clk) disable iff (srst)
      (state_r == SEMC_ST_ACQ_WR) && !pins_r.read_write_n |-> dq_oe_r && !dq_out_r[0];
   endproperty
   a_request_zero: assert property (p_request_zero)
      else $error("Request write does not drive zero.");

   property p_release_one;
      @(posedge core_clk) disable iff (srst)
      ((state_r == SEMC_ST_REL_WR) || (state_r == SEMC_ST_ACQ_REL) || (state_r == SEMC_ST_INIT))
      && !pins_r.read_write_n |-> dq_oe_r && dq_out_r[0];
   endproperty
   a_release_one: assert property (p_release_one)
      else $error("Release write does not drive one.");

   property p_fail_withdraws;
      @(posedge core_clk) disable iff (srst)
      rsp_valid_r && (rsp_r.op == SEMC_OP_ACQUIRE) && !rsp_r.granted |->
         $past(state_r, 2) == SEMC_ST_ACQ_REL;
   endproperty
   a_fail_withdraws: assert property (p_fail_withdraws)
      else $error("Failed acquire left its request standing.");

   property p_boot_init;
      @(posedge core_clk) disable iff (srst)
      boot_r |-> !cmd_ready_r && (state_r == SEMC_ST_INIT);
   endproperty
   a_boot_init: assert property (p_boot_init)
      else $error("Commands accepted before flags freed.");

   property p_grant_matches;
      @(posedge core_clk) disable iff (srst)
      rsp_valid_r && rsp_r.granted |-> (rsp_r.flag == `SEMC_FLAG_TAKEN);
   endproperty
   a_grant_matches: assert property (p_grant_matches)
      else $error("Grant reported without a zero flag.");

   c_acquire_ok:   cover property (@(posedge core_clk) disable iff (srst)
      rsp_valid_r && rsp_r.granted);
   c_acquire_fail: cover property (@(posedge core_clk) disable iff (srst)
      rsp_valid_r && (rsp_r.op == SEMC_OP_ACQUIRE) && !rsp_r.granted);
   c_release:      cover property (@(posedge core_clk) disable iff (srst)
      rsp_valid_r && (rsp_r.op == SEMC_OP_RELEASE));

endmodule : semc_ctrl

// ==== dv/semc_flag_dev.sv ====
// Behavioural model of the dual-port flag device; left port faces the controller.
`include "semc_defs.svh"
module semc_flag_dev
   import semc_pkg::*;
(
   // Left port, wired to the controller.
   input  wire semc_pins_s               l_pins,
   input  wire logic [`SEMC_DATA_W-1:0]  l_dq_out,
   input  wire logic                     l_dq_oe,
   output logic [`SEMC_DATA_W-1:0]       l_dq,
   // Right port, driven by the bench.
   input  wire logic                     r_sel_n,
   input  wire logic                     r_oe_n,
   input  wire logic                     r_rw_n,
   input  wire logic [2:0]               r_idx,
   input  wire logic                     r_wbit,
   output logic [`SEMC_DATA_W-1:0]       r_dq,
   // Left port access counts.
   output int                            l_reads,
   output int                            l_writes
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] req_l = 8'h00;
   logic [7:0] req_r = 8'hFF;
   int         own [8] = '{default: 1};
   logic       l_lat = 1'b1;
   logic       r_lat = 1'b1;
   logic       l_rd_n;
   logic       l_wr_n;
   logic [2:0] l_idx;
   initial l_reads = 0;
   initial l_writes = 0;
   // Flag space needs select low and memory enable high.
   assign l_rd_n = l_pins.flag_space_select_n | l_pins.out_enable_n | ~l_pins.chip_enable_n;
   assign l_wr_n = l_pins.flag_space_select_n | l_pins.read_write_n | ~l_pins.chip_enable_n;
   // Only three index lines decode a flag.
   assign l_idx = l_pins.flag_index_lines;
   task automatic resolve(input int i);
      if (own[i] == 0) begin
         if (!req_l[i]) own[i] = 1;
         else if (!req_r[i]) own[i] = 2;
      end else if (own[i] == 1 && req_l[i]) begin
         own[i] = req_r[i] ? 0 : 2;
      end else if (own[i] == 2 && req_r[i]) begin
         own[i] = req_l[i] ? 0 : 1;
      end
   endtask : resolve
   // Write takes bit zero; a same-instant tie goes to the left.
   always @(negedge l_wr_n) begin
      req_l[l_idx] = l_dq_out[0];
      l_writes++;
      resolve(l_idx);
   end
   always @(negedge r_sel_n or negedge r_rw_n) begin
      if (!r_sel_n && !r_rw_n) begin
         req_r[r_idx] = r_wbit;
         resolve(r_idx);
      end
   end
   // Read value latched when select and output enable go active.
   always @(negedge l_rd_n) begin
      l_lat = (own[l_idx] != 1);
      l_reads++;
   end
   always @(negedge r_sel_n or negedge r_oe_n) begin
      if (!r_sel_n && !r_oe_n) r_lat = (own[r_idx] != 2);
   end
   // Flag spread on every data bit; released bus shows the inverse.
   assign l_dq = l_dq_oe ? l_dq_out :
                 ((!l_rd_n && l_pins.read_write_n) ? {16{l_lat}} : ~{16{l_lat}});
   assign r_dq = (!r_sel_n && !r_oe_n) ? {16{r_lat}} : ~{16{r_lat}};
endmodule : semc_flag_dev

// ==== dv/semc_ctrl_tb_top.sv ====
// Self-checking bench for the semaphore port controller.
`include "semc_defs.svh"
module semc_ctrl_tb_top
   import semc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk = 1'b0;
   logic        srst;
   logic        cmd_valid;
   semc_cmd_s   cmd;
   logic        cmd_ready_r;
   logic        rsp_valid_r;
   semc_rsp_s   rsp_r;
   semc_pins_s  pins_r;
   logic [15:0] dq_in;
   logic [15:0] dq_out_r;
   logic        dq_oe_r;
   logic        r_sel_n, r_oe_n, r_rw_n, r_wbit;
   logic [2:0]  r_idx;
   logic [15:0] r_dq;
   int          l_reads, l_writes;
   int          fails = 0;
   int          checks = 0;
   semc_rsp_s   rsp;
   logic        v;
   int          base;

   always #25ns core_clk = ~core_clk;

   semc_ctrl dut (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r), .rsp_r(rsp_r),
      .pins_r(pins_r), .dq_in(dq_in), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r));

   semc_flag_dev dev (.l_pins(pins_r), .l_dq_out(dq_out_r), .l_dq_oe(dq_oe_r), .l_dq(dq_in),
      .r_sel_n(r_sel_n), .r_oe_n(r_oe_n), .r_rw_n(r_rw_n), .r_idx(r_idx), .r_wbit(r_wbit),
      .r_dq(r_dq), .l_reads(l_reads), .l_writes(l_writes));

   task automatic cmp1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : cmp1

   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : cmp16

   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   // Pin discipline watched on every clock.
   always @(posedge core_clk) begin
      if (!srst) begin
         cmp1(pins_r.chip_enable_n, 1'b1);
         if (dq_oe_r) cmp16(dq_out_r & 16'hFFFE, 16'h0000);
         if (!pins_r.out_enable_n || !pins_r.read_write_n) begin
            cmp1(pins_r.flag_space_select_n, 1'b0);
         end
      end
   end

   task automatic do_cmd(input semc_op_e op, input logic [2:0] idx);
      int n;
      n = 0;
      cmd_valid <= 1'b1;
      cmd <= '{op: op, idx: idx};
      do @(posedge core_clk); while (cmd_ready_r !== 1'b1 && ++n < 400);
      cmd_valid <= 1'b0;
      do @(posedge core_clk); while (rsp_valid_r !== 1'b1 && ++n < 800);
      rsp = rsp_r;
      cmp1(rsp_valid_r, 1'b1);
      cmp16({14'h0000, rsp.op}, {14'h0000, op});
   endtask : do_cmd

   task automatic r_write(input logic [2:0] idx, input logic b);
      r_sel_n <= 1'b0;
      r_idx <= idx;
      r_wbit <= b;
      @(posedge core_clk) r_rw_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      r_rw_n <= 1'b1;
      @(posedge core_clk) r_sel_n <= 1'b1;
      @(posedge core_clk);
   endtask : r_write

   task automatic r_open(input logic [2:0] idx);
      r_sel_n <= 1'b0;
      r_idx <= idx;
      @(posedge core_clk) r_oe_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      v = r_dq[0];
   endtask : r_open

   task automatic r_close();
      r_oe_n <= 1'b1;
      @(posedge core_clk) r_sel_n <= 1'b1;
      @(posedge core_clk);
   endtask : r_close

   task automatic r_read(input logic [2:0] idx, input logic exp);
      r_open(idx);
      r_close();
      cmp1(v, exp);
   endtask : r_read

   // Start-up frees all flags from both sides, then every flag reads free.
   task automatic t_init();
      for (int i = 0; i < 8; i++) r_write(i[2:0], 1'b1);
      while (cmd_ready_r !== 1'b1) @(posedge core_clk);
      cmp16(16'(l_writes), 16'h0008);
      base = l_writes;
      do_cmd(SEMC_OP_INIT, 3'h0);
      cmp16(16'(l_writes - base), 16'h0008);
      for (int i = 0; i < 8; i++) begin
         do_cmd(SEMC_OP_PEEK, i[2:0]);
         cmp1(rsp.flag, 1'b1);
         r_read(i[2:0], 1'b1);
      end
   endtask : t_init

   task automatic t_acquire();
      base = l_writes;
      do_cmd(SEMC_OP_ACQUIRE, 3'h3);
      cmp1(rsp.granted, 1'b1);
      cmp1(rsp.flag, 1'b0);
      cmp16(16'(l_writes - base), 16'h0001);
      r_read(3'h3, 1'b1);
   endtask : t_acquire

   task automatic t_contest();
      r_write(3'h5, 1'b0);
      r_read(3'h5, 1'b0);
      base = l_reads;
      do_cmd(SEMC_OP_ACQUIRE, 3'h5);
      cmp1(rsp.granted, 1'b0);
      cmp1(rsp.flag, 1'b1);
      cmp16(16'(l_reads - base), 16'h0004);
      r_read(3'h5, 1'b0);
      r_write(3'h5, 1'b1);
      r_read(3'h5, 1'b1);
      do_cmd(SEMC_OP_PEEK, 3'h5);
      cmp1(rsp.flag, 1'b1);
   endtask : t_contest

   task automatic t_handover();
      r_write(3'h3, 1'b0);
      r_read(3'h3, 1'b1);
      r_open(3'h3);
      do_cmd(SEMC_OP_RELEASE, 3'h3);
      cmp1(rsp.flag, 1'b1);
      cmp1(rsp.granted, 1'b0);
      cmp1(r_dq[0], 1'b1);
      r_close();
      r_read(3'h3, 1'b0);
      do_cmd(SEMC_OP_PEEK, 3'h3);
      cmp1(rsp.flag, 1'b1);
      r_write(3'h3, 1'b1);
      do_cmd(SEMC_OP_PEEK, 3'h3);
      cmp1(rsp.flag, 1'b1);
      r_read(3'h3, 1'b1);
   endtask : t_handover

   task automatic t_tie();
      fork
         do_cmd(SEMC_OP_ACQUIRE, 3'h7);
         begin
            repeat (3) @(posedge core_clk);
            r_write(3'h7, 1'b0);
         end
      join
      r_open(3'h7);
      r_close();
      cmp1(rsp.granted, v);
   endtask : t_tie

   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      r_sel_n = 1'b1;
      r_oe_n = 1'b1;
      r_rw_n = 1'b1;
      r_wbit = 1'b1;
      r_idx = 3'h0;
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      t_init();
      t_acquire();
      t_contest();
      t_handover();
      t_tie();
      report_and_stop();
   end

   initial begin
      #2000us;
      fails++;
      report_and_stop();
   end
endmodule : semc_ctrl_tb_top
